// ---- src/wdcs_cfg.svh ----
`ifndef WDCS_CFG_SVH
`define WDCS_CFG_SVH

// Register indices on the plain register port
`define WDCS_ADDR_W        4
`define WDCS_OFS_CTRL      4'h0
`define WDCS_OFS_CNT       4'h1
`define WDCS_OFS_MODE      4'h2
`define WDCS_OFS_CSTOP     4'h3
`define WDCS_OFS_PMODE     4'h4
`define WDCS_OFS_ISTAT     4'h5
`define WDCS_OFS_IMASK     4'h6

// Control/status field positions
`define WDCS_CS_B6WI       7
`define WDCS_CS_CNTWE      6
`define WDCS_CS_B4WI       5
`define WDCS_CS_REGWE      4
`define WDCS_CS_BIT2_WRITE_INHIBIT       3
`define WDCS_CS_WATCHDOG_ON_BIT       2
`define WDCS_CS_B0WI       1
`define WDCS_CS_WATCHDOG_RESET_FLAG       0
`define WDCS_CSTOP_STBY    2
`define WDCS_PMODE_SRC     2
`define WDCS_IRQ_OVF       0
`define WDCS_IRQ_RSTEND    1

// Reset values and writable masks
`define WDCS_CKS_RST       4'hf
`define WDCS_CSTOP_RST     8'hff
`define WDCS_CSTOP_WMASK   8'h9f
`define WDCS_PMODE_RST     8'hd8
`define WDCS_PMODE_WMASK   8'h27
`define WDCS_MODE_HI_ONES  4'hf

// Timing counts
`define WDCS_PRE_W         13
`define WDCS_DIV_LOG2_MIN  4'd6
`define WDCS_DIV_LOG2_MAX  4'd13
`define WDCS_SUB_DIV_LAST  5'h1f
`define WDCS_RST_OSC_LAST  10'd511
`define WDCS_RST_OSC_LEN   10'd512

`endif

// ---- src/wdcs_pkg.sv ----
package wdcs_pkg;
    typedef logic [7:0] wdcs_byte_t;
    typedef logic [3:0] wdcs_addr_t;
    typedef enum logic [1:0] {RS_IDLE, RS_WAIT, RS_HOLD} wdcs_rst_state_t;
endpackage

// ---- src/wdcs_sync_pulse.sv ----
`timescale 1ns/1ns
module wdcs_sync_pulse (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic asyncIn,
    output logic      risePulse
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r      <= 1'b0;
            s2_r      <= 1'b0;
            s3_r      <= 1'b0;
            risePulse <= 1'b0;
        end else begin
            s1_r      <= asyncIn;
            s2_r      <= s1_r;
            s3_r      <= s2_r;
            risePulse <= s2_r & ~s3_r;
        end
    end
endmodule

// ---- src/wdcs_clk_sel.sv ----
`timescale 1ns/1ns
`include "wdcs_cfg.svh"
module wdcs_clk_sel #(
    parameter bit HAS_MODE_REG = 1'b1
) (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       srcSel,
    input  wire logic [3:0] divSel,
    input  wire logic       subPulse,
    input  wire logic       oscPulse,
    output logic            srcTick
);
    logic [`WDCS_PRE_W-1:0] pre_r;
    logic [4:0]             subCnt_r;
    logic [3:0]             divLog2;
    logic [`WDCS_PRE_W-1:0] divMask;
    logic                   divTick;
    logic                   fixedTick;
    logic                   subTick;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pre_r    <= '0;
            subCnt_r <= 5'h00;
        end else begin
            pre_r <= pre_r + 13'h0001;
            if (subPulse)
                subCnt_r <= subCnt_r + 5'h01;
        end
    end

    // Codes 1000..1111 give mclk / 2^(6..13)
    assign divLog2   = `WDCS_DIV_LOG2_MIN + {1'b0, divSel[2:0]};
    assign divMask   = 13'h1fff >> (`WDCS_DIV_LOG2_MAX - divLog2);
    assign divTick   = (pre_r & divMask) == divMask;
    assign fixedTick = &pre_r;
    assign subTick   = subPulse && (subCnt_r == `WDCS_SUB_DIV_LAST);
    assign srcTick   = srcSel        ? subTick :
                       !HAS_MODE_REG ? fixedTick :
                       divSel[3]     ? divTick : oscPulse;

    chk_sub_override: assert property (@(posedge mclk) disable iff (!rst_n)
        srcSel && subPulse && subCnt_r != `WDCS_SUB_DIV_LAST |-> !srcTick)
        else $error("source tick while subclock divider mid-count");
    chk_osc_select: assert property (@(posedge mclk) disable iff (!rst_n)
        HAS_MODE_REG && !srcSel && !divSel[3] && !oscPulse |-> !srcTick)
        else $error("oscillator source ticked without oscillator edge");
endmodule

// ---- src/wdcs_watchdog.sv ----
`timescale 1ns/1ns
`include "wdcs_cfg.svh"
// How it works
// - Source-select set forces subclock/32 source
// - Select codes pick mclk divisions or oscillator
// - Standby bit zero halts the watchdog
// - Standby deferred while watchdog stays on
// - Without mode register: /8192 or subclock/32
// - Source-select zero defers to select field
// - Eight-bit counter steps on each tick
// - Two control writes arm the watchdog
// - Mode variant starts running after reset
// - Overflow raises reset one base cycle later
// - Internal reset lasts 512 oscillator cycles
// - Counter preload sets overflow period
// - Overflow sets reset flag, software clears
// - Reset clears the counter
module wdcs_watchdog #(
    parameter bit HAS_MODE_REG = 1'b1
) (
    input  wire logic                mclk,
    input  wire logic                rst_n,
    input  wire logic                subClkPin,
    input  wire logic                oscClkPin,
    input  wire wdcs_pkg::wdcs_addr_t regAddr,
    input  wire wdcs_pkg::wdcs_byte_t regWrData,
    input  wire logic                regWr,
    input  wire logic                regRd,
    output wdcs_pkg::wdcs_byte_t     regRdData,
    output logic                     intRstOut,
    output logic                     wdStandby,
    output logic                     irqOut
);
    import wdcs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic            subPulse;
    logic            oscPulse;
    logic            srcTick;
    wdcs_byte_t      cnt_r;
    logic            cntWe_r;
    logic            regWe_r;
    logic            watchdog_on_bit_r;
    logic            watchdog_reset_flag_r;
    logic [3:0]      mode_r;
    wdcs_byte_t      cstop_r;
    wdcs_byte_t      pmode_r;
    logic [1:0]      istat_r;
    logic [1:0]      imask_r;
    wdcs_rst_state_t rstState_r;
    logic [9:0]      oscCnt_r;
    logic            intRst_r;
    wdcs_byte_t      rdData_r;

    logic            wrCtrl;
    logic            wrCnt;
    logic            wrMode;
    logic            wrCstop;
    logic            wrPmode;
    logic            wrIstat;
    logic            wrImask;
    logic            useSub;
    logic            baseTick;
    logic            cntLoad;
    logic            running;
    logic            ovf;
    logic            rstEnd;
    logic            wdonWrite;
    logic            wrstClear;
    logic [1:0]      irqEvents;
    wdcs_byte_t      csRead;
    wdcs_byte_t      modeRead;
    wdcs_byte_t      rdValue;

    ////////////////////////////////////////////////////////////////////////////
    // Pin-side clocks, brought into mclk as edge pulses

    wdcs_sync_pulse u_subSync (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .asyncIn   (subClkPin),
        .risePulse (subPulse)
    );

    wdcs_sync_pulse u_oscSync (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .asyncIn   (oscClkPin),
        .risePulse (oscPulse)
    );

    wdcs_clk_sel #(
        .HAS_MODE_REG (HAS_MODE_REG)
    ) u_clkSel (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .srcSel   (pmode_r[`WDCS_PMODE_SRC]),
        .divSel   (mode_r),
        .subPulse (subPulse),
        .oscPulse (oscPulse),
        .srcTick  (srcTick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register decode

    assign wrCtrl  = regWr && regAddr == `WDCS_OFS_CTRL;
    assign wrCnt   = regWr && regAddr == `WDCS_OFS_CNT;
    assign wrMode  = regWr && regAddr == `WDCS_OFS_MODE && HAS_MODE_REG;
    assign wrCstop = regWr && regAddr == `WDCS_OFS_CSTOP;
    assign wrPmode = regWr && regAddr == `WDCS_OFS_PMODE;
    assign wrIstat = regWr && regAddr == `WDCS_OFS_ISTAT;
    assign wrImask = regWr && regAddr == `WDCS_OFS_IMASK;

    // Each protect bit gates its neighbour; protect bits are never stored
    assign wdonWrite = wrCtrl && regWe_r && !regWrData[`WDCS_CS_BIT2_WRITE_INHIBIT];
    assign wrstClear = wrCtrl && regWe_r && !regWrData[`WDCS_CS_B0WI]
                       && !regWrData[`WDCS_CS_WATCHDOG_RESET_FLAG];

    ////////////////////////////////////////////////////////////////////////////
    // Counting and standby

    // Standby only takes hold once the watchdog is off
    assign wdStandby = !cstop_r[`WDCS_CSTOP_STBY] && !watchdog_on_bit_r;
    assign running   = watchdog_on_bit_r && !wdStandby && rstState_r == RS_IDLE;
    assign cntLoad   = wrCnt && cntWe_r && !wdStandby && !intRst_r;
    assign ovf       = running && srcTick && !cntLoad && cnt_r == 8'hff;
    assign useSub    = pmode_r[`WDCS_PMODE_SRC];
    assign baseTick  = useSub ? subPulse : 1'b1;
    assign rstEnd    = rstState_r == RS_HOLD && oscPulse && oscCnt_r == `WDCS_RST_OSC_LAST;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            cnt_r <= 8'h00;
        else if (intRst_r)
            cnt_r <= 8'h00;
        else if (cntLoad)
            cnt_r <= regWrData;
        else if (running && srcTick)
            cnt_r <= cnt_r + 8'h01;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control/status register

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cntWe_r <= 1'b0;
            regWe_r <= 1'b0;
            watchdog_on_bit_r  <= HAS_MODE_REG;
        end else if (intRst_r) begin
            cntWe_r <= 1'b0;
            regWe_r <= 1'b0;
            watchdog_on_bit_r  <= HAS_MODE_REG;
        end else begin
            if (wrCtrl && !regWrData[`WDCS_CS_B6WI])
                cntWe_r <= regWrData[`WDCS_CS_CNTWE];
            if (wrCtrl && !regWrData[`WDCS_CS_B4WI])
                regWe_r <= regWrData[`WDCS_CS_REGWE];
            if (wdonWrite)
                watchdog_on_bit_r <= regWrData[`WDCS_CS_WATCHDOG_ON_BIT];
        end
    end

    // Only the pin reset clears the flag; our own reset leaves it for software
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            watchdog_reset_flag_r <= 1'b0;
        else if (ovf)
            watchdog_reset_flag_r <= 1'b1;
        else if (wrstClear)
            watchdog_reset_flag_r <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode, clock stop and port mode registers

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mode_r  <= `WDCS_CKS_RST;
            cstop_r <= `WDCS_CSTOP_RST;
            pmode_r <= `WDCS_PMODE_RST;
        end else begin
            if (wrMode)
                mode_r <= regWrData[3:0];
            if (wrCstop)
                cstop_r <= (cstop_r & ~`WDCS_CSTOP_WMASK) | (regWrData & `WDCS_CSTOP_WMASK);
            if (wrPmode)
                pmode_r <= (pmode_r & ~`WDCS_PMODE_WMASK) | (regWrData & `WDCS_PMODE_WMASK);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Internal reset generator

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rstState_r <= RS_IDLE;
            oscCnt_r   <= 10'd0;
            intRst_r   <= 1'b0;
        end else begin
            case (rstState_r)
                RS_IDLE: begin
                    if (ovf)
                        rstState_r <= RS_WAIT;
                end
                RS_WAIT: begin
                    if (baseTick) begin
                        rstState_r <= RS_HOLD;
                        oscCnt_r   <= 10'd0;
                        intRst_r   <= 1'b1;
                    end
                end
                RS_HOLD: begin
                    if (rstEnd) begin
                        rstState_r <= RS_IDLE;
                        intRst_r   <= 1'b0;
                    end else if (oscPulse) begin
                        oscCnt_r <= oscCnt_r + 10'd1;
                    end
                end
                default: begin
                    rstState_r <= RS_IDLE;
                    intRst_r   <= 1'b0;
                end
            endcase
        end
    end

    assign intRstOut = intRst_r;

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status and mask

    assign irqEvents = {rstEnd, ovf};

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            istat_r <= 2'h0;
            imask_r <= 2'h0;
        end else begin
            // A new event wins over a same-cycle write-one clear
            istat_r <= (istat_r & ~(wrIstat ? regWrData[1:0] : 2'h0)) | irqEvents;
            if (wrImask)
                imask_r <= regWrData[1:0];
        end
    end

    assign irqOut = |(istat_r & imask_r);

    ////////////////////////////////////////////////////////////////////////////
    // Read port, data valid only in the cycle after the strobe

    assign csRead   = {1'b1, cntWe_r, 1'b1, regWe_r, 1'b1, watchdog_on_bit_r, 1'b1, watchdog_reset_flag_r};
    assign modeRead = HAS_MODE_REG ? {`WDCS_MODE_HI_ONES, mode_r} : 8'h00;
    assign rdValue  = regAddr == `WDCS_OFS_CTRL  ? csRead :
                      regAddr == `WDCS_OFS_CNT   ? cnt_r :
                      regAddr == `WDCS_OFS_MODE  ? modeRead :
                      regAddr == `WDCS_OFS_CSTOP ? cstop_r :
                      regAddr == `WDCS_OFS_PMODE ? pmode_r :
                      regAddr == `WDCS_OFS_ISTAT ? {6'h00, istat_r} :
                      regAddr == `WDCS_OFS_IMASK ? {6'h00, imask_r} : 8'h00;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            rdData_r <= 8'h00;
        else
            rdData_r <= regRd ? rdValue : 8'h00;
    end

    assign regRdData = rdData_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    logic [9:0] oscSeen_r;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            oscSeen_r <= 10'd0;
        else if (!intRst_r)
            oscSeen_r <= 10'd0;
        else if (oscPulse)
            oscSeen_r <= oscSeen_r + 10'd1;
    end

    sequence s_ovfSeen;
        ovf && !useSub;
    endsequence

    sequence s_resetRaised;
        rstState_r == RS_WAIT && !intRst_r ##1 intRst_r;
    endsequence

    chk_rst_delay: assert property (@(posedge mclk) disable iff (!rst_n)
        s_ovfSeen |=> s_resetRaised)
        else $error("internal reset not raised one cycle after overflow");
    chk_rst_length: assert property (@(posedge mclk) disable iff (!rst_n)
        $fell(intRst_r) |-> oscSeen_r == `WDCS_RST_OSC_LEN)
        else $error("internal reset length differs from 512 oscillator cycles");
    chk_cnt_step: assert property (@(posedge mclk) disable iff (!rst_n)
        running && srcTick && !cntLoad && !intRst_r |=> cnt_r == $past(cnt_r) + 8'h01)
        else $error("counter did not step by one on a source tick");
    chk_ovf_flag: assert property (@(posedge mclk) disable iff (!rst_n)
        ovf |=> watchdog_reset_flag_r && cnt_r == 8'h00)
        else $error("overflow did not set the reset flag");
    chk_standby_defer: assert property (@(posedge mclk) disable iff (!rst_n)
        watchdog_on_bit_r && !cstop_r[`WDCS_CSTOP_STBY] && rstState_r == RS_IDLE && srcTick && !cntLoad
        |=> cnt_r != $past(cnt_r))
        else $error("standby entered while watchdog is on");
    chk_standby_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        wdStandby && !intRst_r |=> $stable(cnt_r))
        else $error("counter moved in module standby");
    chk_start_seq: assert property (@(posedge mclk) disable iff (!rst_n)
        wdonWrite && regWrData[`WDCS_CS_WATCHDOG_ON_BIT] && !intRst_r |=> watchdog_on_bit_r)
        else $error("armed write did not turn the watchdog on");
    chk_preload_val: assert property (@(posedge mclk) disable iff (!rst_n)
        cntLoad |=> cnt_r == $past(regWrData))
        else $error("counter preload not taken");
    chk_cnt_reset: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(rst_n) |-> cnt_r == 8'h00)
        else $error("counter not cleared by reset");
    chk_watchdog_on_bit_reset: assert property (@(posedge mclk) disable iff (!rst_n)
        !$past(rst_n) |-> watchdog_on_bit_r == HAS_MODE_REG)
        else $error("watchdog-on bit has wrong reset value");
    chk_flag_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
        watchdog_reset_flag_r && !wrstClear |=> watchdog_reset_flag_r)
        else $error("reset flag dropped without a permitted clear");
    chk_ovf_wait: assert property (@(posedge mclk) disable iff (!rst_n)
        ovf |=> rstState_r == RS_WAIT && !intRst_r)
        else $error("overflow did not wait one base cycle");
    chk_sub_wait: assert property (@(posedge mclk) disable iff (!rst_n)
        rstState_r == RS_WAIT && useSub && !subPulse |=> !intRst_r)
        else $error("internal reset raised before a subclock cycle");
    chk_rst_cnt_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        intRst_r |=> cnt_r == 8'h00)
        else $error("counter not cleared by internal reset");
    chk_cnt_hold_off: assert property (@(posedge mclk) disable iff (!rst_n)
        !watchdog_on_bit_r && !cntLoad && !intRst_r |=> $stable(cnt_r))
        else $error("counter moved while watchdog is off");
endmodule

// ---- tb/watchdog_clock_select_and_overflow_test.sv ----
`timescale 1ns/1ns
`include "wdcs_cfg.svh"
module watchdog_clock_select_and_overflow_test;
    import wdcs_pkg::*;

    logic       mclk;
    logic       rst_n;
    logic       subClkPin;
    logic       oscClkPin;
    wdcs_addr_t regAddr;
    wdcs_byte_t regWrData;
    logic       regWr;
    logic       regRd;
    wdcs_byte_t regRdData;
    logic       intRstOut;
    logic       wdStandby;
    logic       irqOut;
    int         errCount;
    int         numChecks;

    wdcs_watchdog #(.HAS_MODE_REG(1'b1)) dut (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .subClkPin (subClkPin),
        .oscClkPin (oscClkPin),
        .regAddr   (regAddr),
        .regWrData (regWrData),
        .regWr     (regWr),
        .regRd     (regRd),
        .regRdData (regRdData),
        .intRstOut (intRstOut),
        .wdStandby (wdStandby),
        .irqOut    (irqOut)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Clocks: oscillator period 10 mclk, subclock period 12 mclk
    logic [3:0] oscDiv;
    logic [3:0] subDiv;
    initial mclk = 1'b0;
    always #2 mclk = ~mclk;
    initial begin
        oscDiv    = 4'h0;
        subDiv    = 4'h3;
        oscClkPin = 1'b0;
        subClkPin = 1'b0;
    end
    always @(posedge mclk) begin
        oscDiv <= (oscDiv == 4'h4) ? 4'h0 : oscDiv + 4'h1;
        subDiv <= (subDiv == 4'h5) ? 4'h0 : subDiv + 4'h1;
        if (oscDiv == 4'h4)
            oscClkPin <= ~oscClkPin;
        if (subDiv == 4'h5)
            subClkPin <= ~subClkPin;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        numChecks++;
        if (seen !== exp) begin
            errCount++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input wdcs_addr_t a, input wdcs_byte_t d);
        @(posedge mclk);
        regWr     <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask

    task automatic rd(input wdcs_addr_t a, output wdcs_byte_t d);
        @(posedge mclk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 d = regRdData;
    endtask

    task automatic rdchk(input string what, input wdcs_addr_t a, input wdcs_byte_t exp);
        wdcs_byte_t d;
        rd(a, d);
        check(what, {8'h00, d}, {8'h00, exp});
    endtask

    // Polls the counter every cycle; the first step may be a leftover of the
    // previous source, so the interval between the 2nd and 3rd steps is taken
    task automatic period_of(input int bound, output int per);
        wdcs_byte_t prev;
        int         n;
        int         t0;
        int         steps;
        steps = 0;
        per   = 0;
        t0    = 0;
        @(posedge mclk);
        regRd   <= 1'b1;
        regAddr <= `WDCS_OFS_CNT;
        @(posedge mclk);
        #1 prev = regRdData;
        for (n = 0; n < bound && steps < 3; n++) begin
            @(posedge mclk);
            #1;
            if (regRdData !== prev) begin
                steps++;
                if (steps == 2) t0 = n;
                if (steps == 3) begin
                    per = n - t0;
                    check("count step", {8'h00, regRdData}, {8'h00, prev + 8'h01});
                end
                prev = regRdData;
            end
        end
        @(posedge mclk);
        regRd <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_values();
        #1;
        check("standby out", {15'h0, wdStandby}, 16'h0);
        check("int reset", {15'h0, intRstOut}, 16'h0);
        check("irq out", {15'h0, irqOut}, 16'h0);
        rdchk("ctrl", `WDCS_OFS_CTRL, 8'hae);
        rdchk("counter", `WDCS_OFS_CNT, 8'h00);
        rdchk("mode", `WDCS_OFS_MODE, 8'hff);
        rdchk("clock stop", `WDCS_OFS_CSTOP, 8'hff);
        rdchk("port mode", `WDCS_OFS_PMODE, 8'hd8);
        rdchk("irq status", `WDCS_OFS_ISTAT, 8'h00);
        wr(4'h7, 8'h5a);
        rdchk("unmapped", 4'h7, 8'h00);
        $display("test reset values done");
    endtask

    task automatic t_clock_codes();
        int per;
        for (int c = 8; c < 16; c++) begin
            wr(`WDCS_OFS_MODE, 8'(c));
            rdchk("mode rb", `WDCS_OFS_MODE, 8'hf0 | 8'(c));
            period_of(3 * (1 << (c - 2)) + 40, per);
            check("div period", 16'(per), 16'(1 << (c - 2)));
        end
        wr(`WDCS_OFS_MODE, 8'h05);
        period_of(80, per);
        check("osc period", 16'(per), 16'd10);
        wr(`WDCS_OFS_MODE, 8'h08);
        wr(`WDCS_OFS_PMODE, 8'h04);
        rdchk("port mode rb", `WDCS_OFS_PMODE, 8'hdc);
        period_of(1300, per);
        check("sub period", 16'(per), 16'd384);
        wr(`WDCS_OFS_PMODE, 8'h00);
        $display("test clock codes done");
    endtask

    task automatic t_start_standby();
        wdcs_byte_t a;
        wdcs_byte_t b;
        int         per;
        wr(`WDCS_OFS_CTRL, 8'h10);
        wr(`WDCS_OFS_CTRL, 8'hb0);
        rdchk("ctrl off", `WDCS_OFS_CTRL, 8'hba);
        rd(`WDCS_OFS_CNT, a);
        repeat (200) @(posedge mclk);
        wr(`WDCS_OFS_CNT, 8'h55);
        rd(`WDCS_OFS_CNT, b);
        check("frozen cnt", {8'h00, b}, {8'h00, a});
        wr(`WDCS_OFS_CTRL, 8'hac);
        rdchk("ctrl inhibit", `WDCS_OFS_CTRL, 8'hba);
        wr(`WDCS_OFS_CSTOP, 8'hfb);
        #1 check("standby on", {15'h0, wdStandby}, 16'h1);
        rdchk("clock stop rb", `WDCS_OFS_CSTOP, 8'hfb);
        wr(`WDCS_OFS_CSTOP, 8'hff);
        #1 check("standby off", {15'h0, wdStandby}, 16'h0);
        wr(`WDCS_OFS_CTRL, 8'h10);
        wr(`WDCS_OFS_CTRL, 8'h24);
        rdchk("ctrl on", `WDCS_OFS_CTRL, 8'hbe);
        wr(`WDCS_OFS_CSTOP, 8'hfb);
        #1 check("deferred", {15'h0, wdStandby}, 16'h0);
        rdchk("stored zero", `WDCS_OFS_CSTOP, 8'hfb);
        period_of(300, per);
        check("still runs", 16'(per), 16'd64);
        wr(`WDCS_OFS_CTRL, 8'ha0);
        #1 check("standby late", {15'h0, wdStandby}, 16'h1);
        wr(`WDCS_OFS_CSTOP, 8'hff);
        $display("test start and standby done");
    endtask

    task automatic t_overflow();
        int n;
        int m;
        wr(`WDCS_OFS_MODE, 8'h08);
        wr(`WDCS_OFS_IMASK, 8'h01);
        wr(`WDCS_OFS_CTRL, 8'h10);
        wr(`WDCS_OFS_CTRL, 8'h24);
        wr(`WDCS_OFS_CTRL, 8'h48);
        wr(`WDCS_OFS_CNT, 8'hfe);
        for (n = 0; n < 400 && intRstOut !== 1'b1; n++) begin
            @(posedge mclk);
            #1;
        end
        // Two ticks from 0xfe, the first at most one period away, then two edges
        check("ovf delay", 16'(n >= 66 && n <= 129), 16'h1);
        #1 check("irq raised", {15'h0, irqOut}, 16'h1);
        rdchk("ctrl flag", `WDCS_OFS_CTRL, 8'haf);
        wr(`WDCS_OFS_CNT, 8'h33);
        rdchk("held cnt", `WDCS_OFS_CNT, 8'h00);
        for (m = 0; m < 6000 && intRstOut !== 1'b0; m++) begin
            @(posedge mclk);
            #1;
        end
        // Six edges spent above; 512 oscillator periods give or take one sync phase
        check("rst length", 16'(m + 6 >= 5110 && m + 6 <= 5121), 16'h1);
        rdchk("irq both", `WDCS_OFS_ISTAT, 8'h03);
        wr(`WDCS_OFS_ISTAT, 8'h01);
        #1 check("irq masked", {15'h0, irqOut}, 16'h0);
        rdchk("irq end", `WDCS_OFS_ISTAT, 8'h02);
        wr(`WDCS_OFS_IMASK, 8'h02);
        #1 check("irq unmask", {15'h0, irqOut}, 16'h1);
        wr(`WDCS_OFS_ISTAT, 8'h02);
        #1 check("irq clear", {15'h0, irqOut}, 16'h0);
        wr(`WDCS_OFS_CTRL, 8'h1c);
        rdchk("flag kept", `WDCS_OFS_CTRL, 8'hbf);
        wr(`WDCS_OFS_CTRL, 8'h3c);
        rdchk("flag clear", `WDCS_OFS_CTRL, 8'hbe);
        $display("test overflow done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("checks %0d mismatches %0d", numChecks, errCount);
        if (errCount == 0 && numChecks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // About 48k cycles expected; cut off well beyond
    initial begin
        #400000;
        errCount++;
        summarize();
    end

    initial begin
        errCount  = 0;
        numChecks = 0;
        rst_n     = 1'b0;
        regAddr   = '0;
        regWrData = '0;
        regWr     = 1'b0;
        regRd     = 1'b0;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_reset_values();
        t_clock_codes();
        t_start_standby();
        t_overflow();
        summarize();
    end
endmodule
